// *** bench/usc_assertions.sv ***
// Port assertions for the strap and flag controller.
// Assumes a bind onto usc_ctrl and a single clock domain.
`timescale 1ns/100ps
module usc_assertions (
	// Clock, reset and line events
	input wire logic       core_clk_i,
	input wire logic       rst_n_i,
	input wire logic       squelch_i,
	input wire logic       test_packet_i,
	input wire logic       pullup_det_i,
	input wire logic       disconnect_i,
	// Outputs watched
	input wire logic       shutdown_o,
	input wire logic       serial_mode_o,
	input wire logic [1:0] edge_boost_o,
	input wire logic [1:0] dc_boost_o,
	input wire logic       high_speed_active_flag_o,
	input wire logic       attach_detect_flag_o,
	input wire logic       sen_pin_out_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Three edges of run: capture, output register, then a settled sample
	pin_boost_tie_a: assert property (
		!serial_mode_o |-> edge_boost_o == dc_boost_o)
		else $error("pin mode boosts differ");
	boost_hold_a: assert property (
		$past(rst_n_i, 3) && !serial_mode_o |-> $stable(edge_boost_o))
		else $error("pin mode boost moved");
	mode_hold_a: assert property (
		$past(rst_n_i, 3) |-> $stable(serial_mode_o))
		else $error("bus mode moved");
	attach_cause_a: assert property (
		$rose(attach_detect_flag_o) |-> $past(pullup_det_i))
		else $error("attach flag without pull-up");
	hs_cause_a: assert property (
		$rose(high_speed_active_flag_o)
		|-> $past(squelch_i) || $past(test_packet_i))
		else $error("high speed flag without cause");
	disc_clear_a: assert property (
		disconnect_i && !pullup_det_i
		|=> !attach_detect_flag_o && !high_speed_active_flag_o)
		else $error("flags kept after disconnect");
	quiet_shut_a: assert property (
		shutdown_o && $past(shutdown_o)
		|-> !high_speed_active_flag_o && !attach_detect_flag_o)
		else $error("flag up in shutdown");
	sen_follow_a: assert property (
		!serial_mode_o && !shutdown_o && !$past(shutdown_o)
		|-> sen_pin_out_o == $past(high_speed_active_flag_o))
		else $error("sensitivity pin not showing flag");
	cover property ($rose(high_speed_active_flag_o));
	cover property ($rose(attach_detect_flag_o));
	cover property ($rose(shutdown_o));
endmodule

bind usc_ctrl usc_assertions chk_u (.core_clk_i, .rst_n_i, .squelch_i,
	.test_packet_i, .pullup_det_i, .disconnect_i, .shutdown_o,
	.serial_mode_o, .edge_boost_o, .dc_boost_o, .high_speed_active_flag_o,
	.attach_detect_flag_o, .sen_pin_out_o);

// *** bench/usc_ctrl_tb.sv ***
// Bench for the strap and flag controller.
// Assumes usc_ctrl, its package, the peer model and the bound checker.
`timescale 1ns/100ps
module usc_ctrl_tb import usc_pkg::*;;
	logic       clk, rst_n, pin, bfl, scl, sda, shut, ser, hs, att;
	logic       sp, spo, cp, cpo;
	logic [1:0] bst, sen, seb, sdb, eb, db, rs;
	logic [6:0] adr;
	logic [7:0] ev;
	wire  [7:0] cfg = {shut, ser, eb, db, rs};
	int         err_total, n_checks, cyc;
	usc_ctrl #(.RST_CYC(4)) dut (
		.core_clk_i(clk), .rst_n_i(rst_n), .active_low_shutdown_pin_i(pin),
		.boost_float_i(bfl), .boost_strap_i(bst), .rx_sensitivity_strap_i(sen),
		.scl_pulled_up_i(scl), .sda_pulled_up_i(sda),
		.ser_edge_boost_i(seb), .ser_dc_boost_i(sdb),
		.usb_reset_i(ev[0]), .chirp_j_i(ev[1]), .chirp_k_i(ev[2]),
		.squelch_i(ev[3]), .fixture_det_i(ev[4]), .test_packet_i(ev[5]),
		.pullup_det_i(ev[6]), .disconnect_i(ev[7]),
		.shutdown_o(shut), .serial_mode_o(ser), .slave_addr_o(adr),
		.edge_boost_o(eb), .dc_boost_o(db), .rx_sensitivity_o(rs),
		.high_speed_active_flag_o(hs), .attach_detect_flag_o(att),
		.sen_pin_out_o(sp), .sen_pin_oe_n_o(spo),
		.scl_pin_out_o(cp), .scl_pin_oe_n_o(cpo));
	usc_usb_peer peer (.clk_i(clk), .ev_o(ev));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic chk(input logic [7:0] g, e);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic cyc_n(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic tend(input string s);
		$display("test %s done, mismatches so far %0d", s, err_total);
	endtask
	// Straps are applied while power-up reset is low
	task automatic pwr(input logic c, d, f, input logic [1:0] b, s);
		rst_n = 1'b0;
		{scl, sda, bfl, bst, sen} = {c, d, f, b, s};
		cyc_n(20);
		rst_n = 1'b1;
		cyc_n(4);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 12000) begin
			err_total++;
			conclude();
		end
	end
	initial begin
		{pin, seb, sdb} = 5'h16;
		pwr(1'b0, 1'b1, 1'b1, 2'h0, 2'h2);
		chk({ser, adr}, 8'h2C);
		chk(cfg, 8'h3E);
		{bfl, bst, sen, scl, sda} = 7'h13;
		cyc_n(5);
		chk(cfg, 8'h3E);
		tend("straps");
		peer.hold(6, 1);
		cyc_n(2);
		chk(8'({att, cp, cpo}), 8'h06);
		tend("attach");
		peer.hs_shake(CHIRP_MIN_CYC, CHIRP_MAX_CYC);
		cyc_n(3);
		chk(8'({hs, sp, spo}), 8'h06);
		peer.hold(7, 1);
		cyc_n(2);
		chk(8'({hs, att, sp, cp}), 8'h00);
		peer.fixture();
		cyc_n(3);
		chk(8'(hs), 8'h01);
		tend("high speed");
		// A pin pulse shorter than the minimum must not shut down
		pin = 1'b0;
		cyc_n(2);
		pin = 1'b1;
		cyc_n(4);
		chk(8'({shut, hs}), 8'h01);
		for (int i = 0; i < 3; i++) begin
			sen = 2'(i);
			pin = 1'b0;
			cyc_n(6);
			chk(8'({shut, hs, att}), 8'h04);
			pin = 1'b1;
			cyc_n(6);
			chk(cfg, 8'h3C | 8'(i));
		end
		tend("shutdown");
		for (int i = 0; i < 4; i++) begin
			pwr(i[1], i[0], 1'b0, 2'h1, 2'h0);
			chk(cfg & 8'hFC, (i == 3) ? 8'h58 : 8'h14);
		end
		chk(8'(spo), 8'h01);
		chk({ser, adr}, 8'hAC);
		tend("modes");
		conclude();
	end
endmodule

// *** bench/usc_usb_peer.sv ***
// USB peer model: line events seen by the front end, one bit each.
// Assumes tasks are called at a falling edge; bits 0..7 are reset, J, K,
// squelch, fixture, test packet, pull-up, disconnect.
`timescale 1ns/100ps
module usc_usb_peer (
	// Clock
	input  wire logic clk_i,
	// Line events
	output logic [7:0] ev_o
);
	initial ev_o = 8'h00;
	task automatic hold(input int b, n);
		ev_o[b] = 1'b1;
		repeat (n) @(negedge clk_i);
		ev_o[b] = 1'b0;
	endtask
	// Chirp lengths chosen by the caller, so slow and prompt peers both run
	task automatic hs_shake(input int jn, kn);
		hold(0, 1);
		hold(1, jn);
		hold(2, kn);
		// Line rests one cycle after K before squelch is reported
		@(negedge clk_i);
		hold(3, 1);
	endtask
	task automatic fixture();
		hold(4, 1);
		hold(5, 1);
	endtask
endmodule

// *** include/usc_pkg.sv ***
// Package for the redriver strap and flag controller.
// Assumes a single 20 MHz core clock and synchronous active-low reset.
package usc_pkg;

	// Core clock
	localparam int unsigned CLK_HZ          = 20_000_000;
	localparam int unsigned CLK_PERIOD_NS   = 50;

	// Times in microseconds
	localparam int unsigned CHIRP_MIN_US    = 18;
	localparam int unsigned CHIRP_MAX_US    = 128;
	localparam int unsigned RST_MIN_US      = 100;

	// Cycle counts: least times round up, longest round down
	localparam int unsigned CHIRP_MIN_CYC   =
		(CHIRP_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CHIRP_MAX_CYC   =
		(CHIRP_MAX_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned RST_MIN_CYC     =
		(RST_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Strap defaults and slave address
	localparam logic [1:0] BOOST_FLOAT_LVL  = 2'h3;
	localparam logic [6:0] SLAVE_ADDR       = 7'h2C;
	localparam int unsigned CNT_W           = 12;

	// Three-level sensitivity strap as seen by the pad detector
	typedef enum logic [1:0] {
		SEN_LOW   = 2'b00,
		SEN_MED   = 2'b01,
		SEN_HIGH  = 2'b10
	} usc_sen_t;

	// High-speed handshake tracker
	typedef enum logic [2:0] {
		HS_IDLE    = 3'b000,
		HS_RESET   = 3'b001,
		HS_CHIRP_J = 3'b010,
		HS_CHIRP_K = 3'b011,
		HS_WAIT_SQ = 3'b100,
		HS_ACTIVE  = 3'b101,
		HS_FIXTURE = 3'b110
	} usc_hs_t;

endpackage

// *** rtl/usc_ctrl.sv ***
// Strap capture, mode select and link status flags of the redriver.
// Assumes line-state events arrive as clean synchronous pulses or levels
// from the analog front end, one core clock domain throughout.
`timescale 1ns/100ps
module usc_ctrl
	import usc_pkg::*;
#(
	parameter int unsigned RST_CYC = RST_MIN_CYC
) (
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       rst_n_i,
	// Shutdown pin
	input  wire logic       active_low_shutdown_pin_i,
	// Straps
	input  wire logic       boost_float_i,
	input  wire logic [1:0] boost_strap_i,
	input  wire logic [1:0] rx_sensitivity_strap_i,
	input  wire logic       scl_pulled_up_i,
	input  wire logic       sda_pulled_up_i,
	// Serial-mode boost settings from the register side
	input  wire logic [1:0] ser_edge_boost_i,
	input  wire logic [1:0] ser_dc_boost_i,
	// Line events from the front end
	input  wire logic       usb_reset_i,
	input  wire logic       chirp_j_i,
	input  wire logic       chirp_k_i,
	input  wire logic       squelch_i,
	input  wire logic       fixture_det_i,
	input  wire logic       test_packet_i,
	input  wire logic       pullup_det_i,
	input  wire logic       disconnect_i,
	// Settings out
	output logic            shutdown_o,
	output logic            serial_mode_o,
	output logic [6:0]      slave_addr_o,
	output logic [1:0]      edge_boost_o,
	output logic [1:0]      dc_boost_o,
	output logic [1:0]      rx_sensitivity_o,
	// Flags and pin drive
	output logic            high_speed_active_flag_o,
	output logic            attach_detect_flag_o,
	output logic            sen_pin_out_o,
	output logic            sen_pin_oe_n_o,
	output logic            scl_pin_out_o,
	output logic            scl_pin_oe_n_o
);

	initial begin
		if (RST_CYC < 1 || RST_CYC >= (1 << CNT_W))
			$error("RST_CYC out of range");
		// The chirp counter must reach past the longest legal chirp
		if (CHIRP_MIN_CYC < 2 || CHIRP_MAX_CYC >= (1 << CNT_W) - 1)
			$error("chirp window does not fit the counter");
	end

	// Filtered shutdown pin
	logic [CNT_W-1:0] low_cnt_r;
	logic             dev_rst_r;
	logic             pin_rst_hit;
	logic             straps_done_r;

	// Captured straps
	logic [1:0] boost_lvl_r;
	logic       serial_r;
	usc_sen_t   sen_r;

	// Handshake tracking
	usc_hs_t          hs_r;
	usc_hs_t          hs_nxt;
	logic [CNT_W-1:0] chirp_cnt_r;
	logic             chirp_ok;
	logic             chirp_long;
	logic             hs_set;
	logic             att_set;
	logic             flags_run;

	// Selections feeding the output registers
	logic             pin_drive;
	logic [1:0]       edge_boost_sel;
	logic [1:0]       dc_boost_sel;

	// Window compare, shared by the chirp length checks
	function automatic logic cnt_between(input logic [CNT_W-1:0] c,
		input logic [CNT_W-1:0] lo, input logic [CNT_W-1:0] hi);
		return (c >= lo) && (c <= hi);
	endfunction

	// Shorter glitches on the pin are ignored, so a bounce cannot shut down
	// The count parks at the threshold, so a long hold never wraps around
	assign pin_rst_hit = (low_cnt_r >= CNT_W'(RST_CYC - 1)) &&
		!active_low_shutdown_pin_i;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || active_low_shutdown_pin_i) begin
			low_cnt_r <= '0;
		end else if (!pin_rst_hit) begin
			low_cnt_r <= low_cnt_r + 1'b1;
		end
	end

	// Power-up reset and a qualified pin reset both hold the block
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || pin_rst_hit) begin
			dev_rst_r <= 1'b1;
		end else if (active_low_shutdown_pin_i) begin
			dev_rst_r <= 1'b0;
		end
	end

	// Boost and mode straps are caught once after power-up only, not on pin resets
	// In pin mode the strap pins turn into flag outputs, so a later read means nothing
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			straps_done_r <= 1'b0;
			boost_lvl_r   <= BOOST_FLOAT_LVL;
			serial_r      <= 1'b0;
		end else if (!straps_done_r) begin
			straps_done_r <= 1'b1;
			boost_lvl_r   <= boost_float_i ? BOOST_FLOAT_LVL
				: boost_strap_i;
			serial_r      <= scl_pulled_up_i && sda_pulled_up_i;
		end
	end

	// Sensitivity is taken at power-up and, in pin mode only, at pin resets; in pin mode the pin is an output afterwards
	// Codes 01 and 11 both read as medium, the level of an open pin
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			sen_r <= SEN_MED;
		end else if (dev_rst_r && !serial_r) begin
			unique case (rx_sensitivity_strap_i)
				2'b10:   sen_r <= SEN_HIGH;
				2'b00:   sen_r <= SEN_LOW;
				default: sen_r <= SEN_MED;
			endcase
		end
	end

	// The entry edge already saw the chirp, so the count trails by one
	assign chirp_ok   = cnt_between(chirp_cnt_r, CNT_W'(CHIRP_MIN_CYC - 1),
		CNT_W'(CHIRP_MAX_CYC - 1));
	// Beyond the window the count parks, so it never wraps to look short
	assign chirp_long = !cnt_between(chirp_cnt_r, '0,
		CNT_W'(CHIRP_MAX_CYC - 1));
	assign flags_run  = straps_done_r && !dev_rst_r;

	// Handshake tracker: reset, one J level, one K level, then squelch;
	// or test fixture, then test packet. Disconnect returns to idle from
	// anywhere. Only one J/K pair is judged; later chirps are not seen.
	// A K that never rises sends the tracker back to idle two cycles after J ends.
	always_comb begin
		hs_nxt = hs_r;
		unique case (hs_r)
			HS_IDLE: begin
				if (fixture_det_i)
					hs_nxt = HS_FIXTURE;
				else if (usb_reset_i)
					hs_nxt = HS_RESET;
			end
			HS_FIXTURE: begin
				if (test_packet_i)
					hs_nxt = HS_ACTIVE;
			end
			HS_RESET: begin
				if (chirp_j_i)
					hs_nxt = HS_CHIRP_J;
			end
			HS_CHIRP_J: begin
				if (!chirp_j_i)
					hs_nxt = chirp_ok ? HS_CHIRP_K : HS_IDLE;
				else if (chirp_long)
					hs_nxt = HS_IDLE;
			end
			HS_CHIRP_K: begin
				if (chirp_k_i && chirp_long)
					hs_nxt = HS_IDLE;
				else if (!chirp_k_i && chirp_cnt_r != '0)
					hs_nxt = chirp_ok ? HS_WAIT_SQ : HS_IDLE;
			end
			HS_WAIT_SQ: begin
				if (squelch_i)
					hs_nxt = HS_ACTIVE;
			end
			HS_ACTIVE: hs_nxt = HS_ACTIVE;
			default:   hs_nxt = HS_IDLE;
		endcase
		if (disconnect_i)
			hs_nxt = HS_IDLE;
	end

	assign hs_set  = (hs_nxt == HS_ACTIVE);
	assign att_set = pullup_det_i && !attach_detect_flag_o;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || dev_rst_r) begin
			hs_r        <= HS_IDLE;
			chirp_cnt_r <= '0;
		end else begin
			hs_r <= hs_nxt;
			if (hs_nxt != hs_r)
				chirp_cnt_r <= '0;
			else if (!chirp_long)
				chirp_cnt_r <= chirp_cnt_r + 1'b1;
		end
	end

	// Pins drive only while running in pin mode
	assign pin_drive      = flags_run && !serial_r;
	assign edge_boost_sel = serial_r ? ser_edge_boost_i
		: boost_lvl_r;
	assign dc_boost_sel   = serial_r ? ser_dc_boost_i
		: boost_lvl_r;

	// High-speed flag follows the tracker; shutdown drops it at once
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || !flags_run) begin
			high_speed_active_flag_o <= 1'b0;
		end else begin
			high_speed_active_flag_o <= hs_set;
		end
	end

	// Set beats a same-cycle disconnect so an attach is not lost
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || !flags_run) begin
			attach_detect_flag_o <= 1'b0;
		end else if (att_set) begin
			attach_detect_flag_o <= 1'b1;
		end else if (disconnect_i) begin
			attach_detect_flag_o <= 1'b0;
		end
	end

	// Mode, address and shutdown status
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			shutdown_o       <= 1'b1;
			serial_mode_o    <= 1'b0;
			slave_addr_o     <= SLAVE_ADDR;
		end else begin
			shutdown_o       <= dev_rst_r;
			serial_mode_o    <= serial_r;
			slave_addr_o     <= SLAVE_ADDR;
		end
	end

	// Boost and sensitivity settings
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			edge_boost_o     <= BOOST_FLOAT_LVL;
			dc_boost_o       <= BOOST_FLOAT_LVL;
			rx_sensitivity_o <= SEN_MED;
		end else begin
			edge_boost_o     <= edge_boost_sel;
			dc_boost_o       <= dc_boost_sel;
			rx_sensitivity_o <= sen_r;
		end
	end

	// Pins stay released until the flags run, and for good in serial mode
	// Released pads rest on their board resistors, not on this block
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			sen_pin_out_o    <= 1'b0;
			sen_pin_oe_n_o   <= 1'b1;
			scl_pin_out_o    <= 1'b0;
			scl_pin_oe_n_o   <= 1'b1;
		end else begin
			sen_pin_out_o    <= high_speed_active_flag_o;
			sen_pin_oe_n_o   <= !pin_drive;
			scl_pin_out_o    <= attach_detect_flag_o;
			scl_pin_oe_n_o   <= !pin_drive;
		end
	end

endmodule
